// [src/ucr_params.svh]
// constants of the per-channel register map: offsets, fields, reset values
`ifndef UCR_PARAMS_SVH
`define UCR_PARAMS_SVH
// ---------------------------------------------------------------
// register offsets (four-bit channel address)
// ---------------------------------------------------------------
`define UCR_OFS_HOLD 4'h0
`define UCR_OFS_IEN 4'h1
`define UCR_OFS_ISRC 4'h2
`define UCR_OFS_LCTL 4'h3
`define UCR_OFS_MCTL 4'h4
`define UCR_OFS_LSTAT 4'h5
`define UCR_OFS_MSTAT 4'h6
`define UCR_OFS_SCR 4'h7
`define UCR_OFS_FEAT 4'h8
`define UCR_OFS_EFN 4'h9
`define UCR_OFS_TXLVL 4'ha
`define UCR_OFS_RXLVL 4'hb
`define UCR_OFS_XCH 4'hc
`define UCR_OFS_STOP2 4'hd
`define UCR_OFS_RES1 4'he
`define UCR_OFS_RES2 4'hf
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define UCR_LCTL_DIV_BIT 7
`define UCR_EFN_ENH_BIT 4
`define UCR_MCTL_LOOP_BIT 4
`define UCR_MCTL_IMM_BIT 3
`define UCR_MCTL_FSEL_BIT 2
`define UCR_FRAC_MDROP_BIT 6
`define UCR_FRAC_POL_BIT 7
`define UCR_FEAT_HDX_BIT 5
`define UCR_IEN_ENH_MASK 8'he0
`define UCR_ISRC_ENH_MASK 8'h30
`define UCR_FCTL_ENH_MASK 8'h30
`define UCR_MCTL_ENH_MASK 8'he0
// ---------------------------------------------------------------
// reset values and timing
// ---------------------------------------------------------------
`define UCR_RST_BYTE 8'h00
`define UCR_DLY_UNIT_CYC 8'h10
`endif

// [src/ucr_pkg.sv]
// types shared by the register map modules
package ucr_pkg;
  typedef enum logic [2:0] {
    UCR_DIR_IDLE = 3'b001,
    UCR_DIR_TX = 3'b010,
    UCR_DIR_HOLD = 3'b100
  } ucr_dir_state_t;
endpackage

// [src/ucr_dir_if.sv]
// carrier between the register map and the half-duplex direction timer
interface ucr_dir_if;
  logic enable;
  logic [3:0] delay;
  logic tx_busy;
  logic dir_active;
  modport ctrl (output enable, output delay, output tx_busy, input dir_active);
  modport timer (input enable, input delay, input tx_busy, output dir_active);
endinterface

// [src/ucr_dir_timer.sv]
// half-duplex direction output timer with turnaround delay
`include "ucr_params.svh"
module ucr_dir_timer
  import ucr_pkg::*;
(
  input wire logic mclk_i, // system clock
  input wire logic rst_n_i, // async reset, low active
  ucr_dir_if.timer dir // settings and transmit activity
);
  ucr_dir_state_t state_reg;
  logic [11:0] cnt_reg;

  // ---------------------------------------------------------------
  // direction sequencer
  // ---------------------------------------------------------------
  // delay counts in units of a sixteen-clock bit slice after the last stop bit
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= UCR_DIR_IDLE;
      cnt_reg <= 12'h000;
    end else begin
      case (state_reg)
        UCR_DIR_IDLE: begin
          if (dir.enable && dir.tx_busy) begin
            state_reg <= UCR_DIR_TX;
          end
        end
        UCR_DIR_TX: begin
          if (!dir.tx_busy) begin
            state_reg <= UCR_DIR_HOLD;
            cnt_reg <= 12'(dir.delay) * 12'(`UCR_DLY_UNIT_CYC);
          end
        end
        UCR_DIR_HOLD: begin
          if (dir.tx_busy) begin
            state_reg <= UCR_DIR_TX;
          end else if (cnt_reg == 12'h000) begin
            state_reg <= UCR_DIR_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 12'h001;
          end
        end
        default: begin
          state_reg <= UCR_DIR_IDLE;
        end
      endcase
    end
  end

  // active while sending and during the turnaround hold
  assign dir.dir_active = (state_reg != UCR_DIR_IDLE);
endmodule

// [src/ucr_regmap.sv]
// per-channel register map of an enhanced serial channel
//
// Behaviour
// - enhanced interrupt, fifo, modem control fields and status-slot write need enable bit 4
// - modem control bits 3 and 2 drive no package pin
// - modem control bits 3 and 2 are storage, looped back in loopback mode
// - modem control bit 3 also requests immediate character transmit
// - modem control bit 2 picks rts/cts or dtr/dsr hardware flow pair
// - divisor registers visible only while line control bit 7 is one
// - modem control bit 4 enables loopback, tx shift output feeds rx input
// - turnaround delay from status-slot write upper nibble releases direction output
// - divisor fraction bit 6 enables multidrop nine-bit addressing
`include "ucr_params.svh"
module ucr_regmap
  import ucr_pkg::*;
(
  input wire logic mclk_i, // system clock, 25 MHz
  input wire logic rst_n_i, // async reset, low active
  input wire logic [3:0] addr_i, // channel register offset
  input wire logic wr_i, // write strobe, one cycle
  input wire logic rd_i, // read strobe, one cycle
  input wire logic [7:0] wdata_i, // write data
  output logic [7:0] rdata_o, // read data, registered
  input wire logic [7:0] rx_data_i, // receive holding byte from receiver
  output logic rx_pop_o, // receive holding read pulse
  output logic [7:0] tx_data_o, // transmit holding byte, registered
  output logic tx_push_o, // transmit holding write pulse
  input wire logic [7:0] line_status_i, // line status from datapath
  input wire logic [3:0] int_source_i, // interrupt source code
  input wire logic [3:0] modem_delta_i, // modem delta flags
  input wire logic [3:0] flow_flag_set_i, // flow character events, pulses
  input wire logic [7:0] tx_level_i, // transmit fifo level
  input wire logic [7:0] rx_level_i, // receive fifo level
  input wire logic cts_n_i, // clear-to-send pin, async
  input wire logic dsr_n_i, // data-set-ready pin, async
  input wire logic cd_n_i, // carrier-detect pin, async
  input wire logic ri_n_i, // ring pin, async
  input wire logic tx_shift_i, // transmit shift output
  input wire logic tx_busy_i, // transmitter has a character in flight
  output logic rx_shift_o, // receive shift input
  input wire logic rx_pin_i, // serial receive pin, async
  output logic tx_pin_o, // serial transmit pin
  output logic rts_n_o, // request-to-send pin
  output logic dtr_n_o, // data-terminal-ready pin
  output logic [7:0] fifo_control_o, // last fifo control write
  output logic fifo_ctl_wr_o, // fifo control write pulse
  output logic [15:0] divisor_o, // baud divisor
  output logic [3:0] divisor_frac_o, // fractional divisor
  output logic multidrop_o, // nine-bit addressing enable
  output logic tx_immediate_o, // immediate transmit request
  output logic flow_sel_dtr_o, // hardware flow uses dtr/dsr
  output logic [3:0] hdx_disables_o, // tx/rx disable controls
  output logic loopback_o // internal loopback active
);
  logic [7:0] div_lo_reg, div_hi_reg, div_frac_reg, int_en_reg, line_ctl_reg, modem_ctl_reg;
  logic [7:0] scratch_reg, feature_reg, enh_func_reg, tx_trig_reg, rx_trig_reg, fifo_ctl_reg;
  logic [7:0] hdx_cfg_reg, stop_one_reg, stop_two_reg, resume_one_reg, resume_two_reg;
  logic [3:0] flow_flag_reg, flow_flag_next;
  logic [3:0] delta_reg;
  logic [3:0] pin_s1, pin_s2, pin_s3, pin_reg;
  logic [1:0] rxp_s;
  logic rxp_s3, rxp_reg;
  logic div_sel, enh;
  logic [7:0] rd_next;
  logic [3:0] modem_in;
  ucr_dir_if dir_bus ();

  assign div_sel = line_ctl_reg[`UCR_LCTL_DIV_BIT];
  assign enh = enh_func_reg[`UCR_EFN_ENH_BIT];

  // ---------------------------------------------------------------
  // pin synchronisers: three stages, change taken when two and three agree
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_s1 <= 4'hf;
      pin_s2 <= 4'hf;
      pin_s3 <= 4'hf;
      pin_reg <= 4'hf;
    end else begin
      pin_s1 <= {cd_n_i, ri_n_i, dsr_n_i, cts_n_i};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      if (pin_s2 == pin_s3) begin
        pin_reg <= pin_s3;
      end
    end
  end

  // receive pin synchroniser, idles high
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rxp_s <= 2'b11;
      rxp_s3 <= 1'b1;
      rxp_reg <= 1'b1;
    end else begin
      rxp_s <= {rxp_s[0], rx_pin_i};
      rxp_s3 <= rxp_s[1];
      if (rxp_s[1] == rxp_s3) begin
        rxp_reg <= rxp_s3;
      end
    end
  end

  // ---------------------------------------------------------------
  // writable registers
  // ---------------------------------------------------------------
  // enhanced bits are masked on write while enhanced bit 4 is clear
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_lo_reg <= `UCR_RST_BYTE;
      div_hi_reg <= `UCR_RST_BYTE;
      div_frac_reg <= `UCR_RST_BYTE;
      int_en_reg <= `UCR_RST_BYTE;
      line_ctl_reg <= `UCR_RST_BYTE;
      modem_ctl_reg <= `UCR_RST_BYTE;
      scratch_reg <= `UCR_RST_BYTE;
      feature_reg <= `UCR_RST_BYTE;
      enh_func_reg <= `UCR_RST_BYTE;
      tx_trig_reg <= `UCR_RST_BYTE;
      rx_trig_reg <= `UCR_RST_BYTE;
      fifo_ctl_reg <= `UCR_RST_BYTE;
      hdx_cfg_reg <= `UCR_RST_BYTE;
      stop_one_reg <= `UCR_RST_BYTE;
      stop_two_reg <= `UCR_RST_BYTE;
      resume_one_reg <= `UCR_RST_BYTE;
      resume_two_reg <= `UCR_RST_BYTE;
    end else if (wr_i) begin
      case (addr_i)
        `UCR_OFS_HOLD: begin
          if (div_sel) begin
            div_lo_reg <= wdata_i;
          end
        end
        `UCR_OFS_IEN: begin
          if (div_sel) begin
            div_hi_reg <= wdata_i;
          end else begin
            int_en_reg <= enh ? wdata_i : (wdata_i & ~`UCR_IEN_ENH_MASK);
          end
        end
        `UCR_OFS_ISRC: begin
          if (div_sel) begin
            div_frac_reg <= wdata_i;
          end else begin
            fifo_ctl_reg <= enh ? wdata_i : (wdata_i & ~`UCR_FCTL_ENH_MASK);
          end
        end
        `UCR_OFS_LCTL: line_ctl_reg <= wdata_i;
        `UCR_OFS_MCTL: modem_ctl_reg <= enh ? wdata_i : (wdata_i & ~`UCR_MCTL_ENH_MASK);
        `UCR_OFS_MSTAT: begin
          if (enh) begin
            hdx_cfg_reg <= wdata_i;
          end
        end
        `UCR_OFS_SCR: scratch_reg <= wdata_i;
        `UCR_OFS_FEAT: feature_reg <= wdata_i;
        `UCR_OFS_EFN: enh_func_reg <= wdata_i;
        `UCR_OFS_TXLVL: tx_trig_reg <= wdata_i;
        `UCR_OFS_RXLVL: rx_trig_reg <= wdata_i;
        `UCR_OFS_XCH: stop_one_reg <= wdata_i;
        `UCR_OFS_STOP2: stop_two_reg <= wdata_i;
        `UCR_OFS_RES1: resume_one_reg <= wdata_i;
        `UCR_OFS_RES2: resume_two_reg <= wdata_i;
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // self-clearing flags
  // ---------------------------------------------------------------
  // a set arriving in the read cycle survives the clear
  always_comb begin
    flow_flag_next = flow_flag_reg;
    if (rd_i && addr_i == `UCR_OFS_XCH) begin
      flow_flag_next = 4'h0;
    end
    flow_flag_next = flow_flag_next | flow_flag_set_i;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flow_flag_reg <= 4'h0;
      delta_reg <= 4'h0;
    end else begin
      flow_flag_reg <= flow_flag_next;
      if (rd_i && addr_i == `UCR_OFS_MSTAT) begin
        delta_reg <= modem_delta_i;
      end else begin
        delta_reg <= delta_reg | modem_delta_i;
      end
    end
  end

  // modem inputs: loopback feeds the control outputs back, pins ignored
  // bits 3..0 order: cd, ri, dsr, cts (true level)
  always_comb begin
    if (modem_ctl_reg[`UCR_MCTL_LOOP_BIT]) begin
      modem_in = {modem_ctl_reg[`UCR_MCTL_IMM_BIT], modem_ctl_reg[`UCR_MCTL_FSEL_BIT],
                  modem_ctl_reg[0], modem_ctl_reg[1]};
    end else begin
      modem_in = ~pin_reg;
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  // unlisted bits read zero; interrupt source top bits mirror fifo enable
  always_comb begin
    rd_next = 8'h00;
    case (addr_i)
      `UCR_OFS_HOLD: rd_next = div_sel ? div_lo_reg : rx_data_i;
      `UCR_OFS_IEN: rd_next = div_sel ? div_hi_reg : int_en_reg;
      `UCR_OFS_ISRC: begin
        if (div_sel) begin
          rd_next = div_frac_reg;
        end else begin
          rd_next = {fifo_ctl_reg[0], fifo_ctl_reg[0], 2'b00, int_source_i};
          if (!enh) begin
            rd_next = rd_next & ~`UCR_ISRC_ENH_MASK;
          end
        end
      end
      `UCR_OFS_LCTL: rd_next = line_ctl_reg;
      `UCR_OFS_MCTL: rd_next = modem_ctl_reg;
      `UCR_OFS_LSTAT: rd_next = line_status_i;
      `UCR_OFS_MSTAT: rd_next = {modem_in, delta_reg | modem_delta_i};
      `UCR_OFS_SCR: rd_next = scratch_reg;
      `UCR_OFS_FEAT: rd_next = feature_reg;
      `UCR_OFS_EFN: rd_next = enh_func_reg;
      `UCR_OFS_TXLVL: rd_next = tx_level_i;
      `UCR_OFS_RXLVL: rd_next = rx_level_i;
      `UCR_OFS_XCH: rd_next = {4'h0, flow_flag_reg};
      default: rd_next = 8'h00;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= 8'h00;
      tx_data_o <= 8'h00;
    end else begin
      if (rd_i) begin
        rdata_o <= rd_next;
      end
      if (wr_i && addr_i == `UCR_OFS_HOLD && !div_sel) begin
        tx_data_o <= wdata_i;
      end
    end
  end

  // holding strobes only when the shared slot is not banked to the divisor
  assign rx_pop_o = rd_i && addr_i == `UCR_OFS_HOLD && !div_sel;
  assign tx_push_o = wr_i && addr_i == `UCR_OFS_HOLD && !div_sel;
  assign fifo_ctl_wr_o = wr_i && addr_i == `UCR_OFS_ISRC && !div_sel;

  // ---------------------------------------------------------------
  // control outputs
  // ---------------------------------------------------------------
  assign fifo_control_o = fifo_ctl_reg;
  assign divisor_o = {div_hi_reg, div_lo_reg};
  assign divisor_frac_o = div_frac_reg[3:0];
  assign multidrop_o = div_frac_reg[`UCR_FRAC_MDROP_BIT];
  assign tx_immediate_o = modem_ctl_reg[`UCR_MCTL_IMM_BIT];
  assign flow_sel_dtr_o = modem_ctl_reg[`UCR_MCTL_FSEL_BIT];
  assign hdx_disables_o = hdx_cfg_reg[3:0];
  assign loopback_o = modem_ctl_reg[`UCR_MCTL_LOOP_BIT];

  // loopback: tx shift into rx shift, line held at mark
  assign rx_shift_o = loopback_o ? tx_shift_i : rxp_reg;
  assign tx_pin_o = loopback_o ? 1'b1 : tx_shift_i;

  // ---------------------------------------------------------------
  // direction control and pins
  // ---------------------------------------------------------------
  assign dir_bus.enable = feature_reg[`UCR_FEAT_HDX_BIT];
  assign dir_bus.delay = hdx_cfg_reg[7:4];
  assign dir_bus.tx_busy = tx_busy_i;

  ucr_dir_timer u_dir (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .dir(dir_bus.timer)
  );

  // bits 3 and 2 reach no pin; in half-duplex mode the direction output
  // replaces the selected control pin, polarity from fraction register bit 7
  always_comb begin
    rts_n_o = ~modem_ctl_reg[1];
    dtr_n_o = ~modem_ctl_reg[0];
    if (dir_bus.enable) begin
      if (flow_sel_dtr_o) begin
        dtr_n_o = dir_bus.dir_active ^ ~div_frac_reg[`UCR_FRAC_POL_BIT];
      end else begin
        rts_n_o = dir_bus.dir_active ^ ~div_frac_reg[`UCR_FRAC_POL_BIT];
      end
    end
    if (loopback_o) begin
      rts_n_o = 1'b1;
      dtr_n_o = 1'b1;
    end
  end
endmodule

// [verif/ucr_regmap_sva.sv]
// checker for the channel register map, watching the top ports only
module ucr_regmap_sva (
  input wire logic mclk_i, // clock
  input wire logic rst_n_i, // reset, low
  input wire logic [3:0] addr_i, // offset
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  input wire logic [7:0] wdata_i, // write data
  input wire logic rx_pop_o, // rx pop
  input wire logic tx_push_o, // tx push
  input wire logic [7:0] tx_data_o, // tx byte
  input wire logic tx_shift_i, // tx shift
  input wire logic rx_shift_o, // rx shift
  input wire logic tx_pin_o, // tx pin
  input wire logic rts_n_o, // rts pin
  input wire logic dtr_n_o, // dtr pin
  input wire logic loopback_o, // loopback
  input wire logic multidrop_o, // multidrop
  input wire logic tx_immediate_o, // immediate tx
  input wire logic flow_sel_dtr_o, // flow select
  input wire logic fifo_ctl_wr_o, // fifo control pulse
  input wire logic [3:0] hdx_disables_o // disables
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // one domain, so clock and reset are given once
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  a_pop_needs_read: assert property (rx_pop_o |-> rd_i && addr_i == 4'h0)
    else $error("rx pop without read at offset zero");
  a_push_needs_write: assert property (tx_push_o |-> wr_i && addr_i == 4'h0)
    else $error("tx push without write at offset zero");
  a_push_data_held: assert property (tx_push_o |=> tx_data_o == $past(wdata_i))
    else $error("tx byte differs from written byte");
  a_loop_route: assert property (loopback_o |-> rx_shift_o == tx_shift_i)
    else $error("loopback does not route tx shift to rx");
  a_loop_pins: assert property (loopback_o |-> tx_pin_o && rts_n_o && dtr_n_o)
    else $error("pins not idle during loopback");
  a_loop_by_write: assert property ($changed(loopback_o) |->
    $past(wr_i) && $past(addr_i) == 4'h4)
    else $error("loopback changed without control write");
  a_imm_by_write: assert property ($changed(tx_immediate_o) |->
    $past(wr_i) && $past(addr_i) == 4'h4)
    else $error("immediate tx changed without control write");
  a_flow_by_write: assert property ($changed(flow_sel_dtr_o) |->
    $past(wr_i) && $past(addr_i) == 4'h4)
    else $error("flow select changed without control write");
  a_mdrop_by_write: assert property ($changed(multidrop_o) |->
    $past(wr_i) && $past(addr_i) == 4'h2)
    else $error("multidrop changed without divisor write");
  a_fctl_needs_write: assert property (fifo_ctl_wr_o |-> wr_i && addr_i == 4'h2)
    else $error("fifo control pulse without write at offset two");
  a_dis_by_write: assert property ($changed(hdx_disables_o) |->
    $past(wr_i) && $past(addr_i) == 4'h6)
    else $error("disables changed without status slot write");
endmodule

bind ucr_regmap ucr_regmap_sva i_sva (.mclk_i, .rst_n_i, .addr_i, .wr_i, .rd_i,
  .wdata_i, .rx_pop_o, .tx_push_o, .tx_data_o, .tx_shift_i, .rx_shift_o, .tx_pin_o,
  .rts_n_o, .dtr_n_o, .loopback_o, .multidrop_o, .tx_immediate_o, .flow_sel_dtr_o,
  .fifo_ctl_wr_o, .hdx_disables_o);

// [verif/testbench.sv]
// self-checking bench for the channel register map
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("Error t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 0, rst_n_i = 0, wr_i = 0, rd_i = 0, tx_shift_i = 0, tx_busy_i = 0;
  logic cts_n_i = 1, dsr_n_i = 1, cd_n_i = 1, ri_n_i = 1, rx_pin_i = 1;
  logic [3:0] addr_i = 4'h0, int_source_i = 4'h0, modem_delta_i = 4'h0, flow_flag_set_i = 4'h0;
  logic [7:0] wdata_i = 8'h00, rx_data_i = 8'h00, line_status_i = 8'h00;
  logic [7:0] tx_level_i = 8'h00, rx_level_i = 8'h00;
  logic [7:0] rdata_o, tx_data_o, fifo_control_o;
  logic [15:0] divisor_o;
  logic [3:0] divisor_frac_o, hdx_disables_o;
  logic rx_pop_o, tx_push_o, rx_shift_o, tx_pin_o, rts_n_o, dtr_n_o, fifo_ctl_wr_o;
  logic multidrop_o, tx_immediate_o, flow_sel_dtr_o, loopback_o;
  int bad_count = 0, n_checks = 0;
  logic [7:0] d;
  ucr_regmap i_dut (.mclk_i, .rst_n_i, .addr_i, .wr_i, .rd_i, .wdata_i, .rdata_o,
    .rx_data_i, .rx_pop_o, .tx_data_o, .tx_push_o, .line_status_i, .int_source_i,
    .modem_delta_i, .flow_flag_set_i, .tx_level_i, .rx_level_i, .cts_n_i, .dsr_n_i,
    .cd_n_i, .ri_n_i, .tx_shift_i, .tx_busy_i, .rx_shift_o, .rx_pin_i, .tx_pin_o,
    .rts_n_o, .dtr_n_o, .fifo_control_o, .fifo_ctl_wr_o, .divisor_o, .divisor_frac_o,
    .multidrop_o, .tx_immediate_o, .flow_sel_dtr_o, .hdx_disables_o, .loopback_o);
  // 25 MHz clock
  always #20 mclk_i = ~mclk_i;
  // ---------------------------------------------------------------
  // bus cycles: one strobe cycle, then a gap so strobes never merge
  // ---------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    @(posedge mclk_i);
    #1 v = rdata_o;
  endtask
  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_divisor;
    wr(4'h3, 8'h80);
    wr(4'h0, 8'h0c);
    wr(4'h1, 8'h12);
    wr(4'h2, 8'h43);
    `CHK(divisor_o, 16'h120c)
    `CHK(multidrop_o, 1'b1)
    `CHK(divisor_frac_o, 4'h3)
    `CHK(tx_data_o, 8'h00)
    rd(4'h0, d);
    `CHK(d, 8'h0c)
    wr(4'h3, 8'h00);
    rx_data_i <= 8'h3c;
    // strobes driven by hand so the one-cycle pulses are seen while they stand
    @(posedge mclk_i);
    addr_i <= 4'h2;
    wdata_i <= 8'h00;
    wr_i <= 1'b1;
    #1 `CHK({fifo_ctl_wr_o, tx_push_o, rx_pop_o}, 3'b100)
    @(posedge mclk_i);
    wr_i <= 1'b0;
    addr_i <= 4'h0;
    rd_i <= 1'b1;
    #1 `CHK({fifo_ctl_wr_o, tx_push_o, rx_pop_o}, 3'b001)
    @(posedge mclk_i);
    rd_i <= 1'b0;
    wr(4'h0, 8'ha5);
    `CHK(tx_data_o, 8'ha5)
    `CHK(divisor_o, 16'h120c)
    rd(4'h0, d);
    `CHK(d, 8'h3c)
  endtask
  // enhanced fields stay dead until the enable bit is set
  task automatic t_enh;
    int_source_i <= 4'h3;
    wr(4'h1, 8'hef);
    rd(4'h1, d);
    `CHK(d, 8'h0f)
    wr(4'h2, 8'h30);
    `CHK(fifo_control_o, 8'h00)
    rd(4'h2, d);
    `CHK(d, 8'h03)
    wr(4'h4, 8'he0);
    rd(4'h4, d);
    `CHK(d, 8'h00)
    wr(4'h6, 8'h5a);
    `CHK(hdx_disables_o, 4'h0)
    wr(4'h9, 8'h10);
    wr(4'h1, 8'hef);
    rd(4'h1, d);
    `CHK(d, 8'hef)
    wr(4'h2, 8'h30);
    `CHK(fifo_control_o, 8'h30)
    wr(4'h6, 8'h5a);
    `CHK(hdx_disables_o, 4'ha)
  endtask
  // bits 3 and 2 are storage and controls, never pins
  task automatic t_mcr;
    wr(4'h4, 8'h0c);
    `CHK(tx_immediate_o, 1'b1)
    `CHK(flow_sel_dtr_o, 1'b1)
    `CHK({rts_n_o, dtr_n_o}, 2'b11)
    rd(4'h4, d);
    `CHK(d, 8'h0c)
    wr(4'h4, 8'h03);
    `CHK({rts_n_o, dtr_n_o, tx_immediate_o, flow_sel_dtr_o}, 4'h0)
  endtask
  task automatic t_loop;
    wr(4'h4, 8'h1c);
    `CHK(loopback_o, 1'b1)
    repeat (6) @(posedge mclk_i);
    rd(4'h6, d);
    `CHK(d[7:4], 4'hc)
    @(posedge mclk_i);
    tx_shift_i <= 1'b1;
    rx_pin_i <= 1'b0;
    @(posedge mclk_i);
    #1 `CHK({rx_shift_o, tx_pin_o, rts_n_o}, 3'b111)
    wr(4'h4, 8'h00);
    repeat (6) @(posedge mclk_i);
    #1 `CHK({rx_shift_o, tx_pin_o, loopback_o}, 3'b010)
  endtask
  // direction held about sixteen clocks per delay step after busy drops
  task automatic t_dir;
    int n;
    wr(4'h8, 8'h20);
    wr(4'h6, 8'h10);
    @(posedge mclk_i);
    tx_busy_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    #1 `CHK({rts_n_o, dtr_n_o}, 2'b01)
    @(posedge mclk_i);
    tx_busy_i <= 1'b0;
    n = 0;
    while (rts_n_o !== 1'b1 && n < 100) begin
      @(posedge mclk_i);
      #1 n++;
    end
    `CHK(n > 12 && n < 24, 1'b1)
    if (n >= 100) finish_test();
  endtask
  task automatic t_status;
    line_status_i <= 8'h61;
    tx_level_i <= 8'h2a;
    rx_level_i <= 8'h15;
    rd(4'h5, d);
    `CHK(d, 8'h61)
    rd(4'ha, d);
    `CHK(d, 8'h2a)
    rd(4'hb, d);
    `CHK(d, 8'h15)
    wr(4'h7, 8'h5a);
    rd(4'h7, d);
    `CHK(d, 8'h5a)
    @(posedge mclk_i);
    flow_flag_set_i <= 4'h5;
    @(posedge mclk_i);
    flow_flag_set_i <= 4'h0;
    rd(4'hc, d);
    `CHK(d, 8'h05)
    rd(4'hc, d);
    `CHK(d, 8'h00)
  endtask
  initial begin
    repeat (10) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    #1 `CHK({divisor_o, loopback_o, rts_n_o, dtr_n_o}, 19'h00003)
    t_divisor();
    t_enh();
    t_mcr();
    t_loop();
    t_dir();
    t_status();
    finish_test();
  end
endmodule
